// >>> pkg/ssu_pkg.sv
// Constants for the synchronous serial unit
// What this block does
// - Master clock from 16-bit baud generator
// - Slave never drives clock, uses external
// - Word length programmable two to eight
// - Shift order LSB or MSB first
// - Idle clock level selectable
// - Shift on leading or trailing edge
// - Full and half duplex, both roles
// - Interrupt when transmit buffer empties
// - Interrupt when received word buffered
// - Error interrupt on four faults
// - Master sends on tx line, slave reverse
// - One clock pin, driven only as master
// - Holding buffers in front of shifter
package ssu_pkg;
  localparam int unsigned BAUD_W     = 16;   // Baud reload width
  localparam int unsigned DATA_W     = 8;    // Widest word
  localparam int unsigned MIN_BITS   = 2;    // Narrowest word
  localparam int unsigned LEN_W      = 4;    // Bit counter width
  localparam int unsigned FLAG_W     = 6;    // Number of status flags
  // Flag positions
  localparam int unsigned F_TX_EMPTY = 0;
  localparam int unsigned F_RX_FULL  = 1;
  localparam int unsigned F_RX_ERR   = 2;
  localparam int unsigned F_PH_ERR   = 3;
  localparam int unsigned F_BR_ERR   = 4;
  localparam int unsigned F_TX_ERR   = 5;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 6'h01; // Tx empty at reset
  // Transfer states
  typedef enum logic [2:0] {
    SSU_IDLE  = 3'b001,
    SSU_SHIFT = 3'b010,
    SSU_DONE  = 3'b100
  } ssu_state_t;
endpackage

// >>> rtl/ssu_port.sv
// Synchronous serial unit: master/slave shift engine with buffers
`timescale 1ns/1ps
module ssu_port #(
  parameter int unsigned DATA_W = ssu_pkg::DATA_W
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // Configuration, held stable while busy
  input  wire logic                        master_en,
  input  wire logic [3:0]                  word_bits,
  input  wire logic                        msb_first,
  input  wire logic                        clk_idle_high,
  input  wire logic                        shift_trailing,
  input  wire logic                        tx_enable,
  input  wire logic                        rx_enable,
  input  wire logic [ssu_pkg::BAUD_W-1:0]  baud_reload,
  // CPU side
  input  wire logic [DATA_W-1:0]           tx_data,
  input  wire logic                        tx_write,
  output logic      [DATA_W-1:0]           rx_data,
  input  wire logic                        rx_read,
  output logic                             busy,
  // Status and interrupts
  output logic      [ssu_pkg::FLAG_W-1:0]  status,
  input  wire logic [ssu_pkg::FLAG_W-1:0]  status_clear,
  input  wire logic [ssu_pkg::FLAG_W-1:0]  irq_enable,
  output logic                             irq_tx,
  output logic                             irq_rx,
  output logic                             irq_err,
  // Serial pins
  input  wire logic                        sclk_in,
  output logic                             master_shift_clock_out,
  output logic                             sclk_oe,
  input  wire logic                        master_tx_slave_rx_line_in,
  output logic                             master_tx_slave_rx_line_out,
  output logic                             master_tx_slave_rx_line_oe,
  input  wire logic                        master_rx_slave_tx_line_in,
  output logic                             master_rx_slave_tx_line_out,
  output logic                             master_rx_slave_tx_line_oe
);
  if (DATA_W != ssu_pkg::DATA_W) begin : g_bad
    $error("ssu_port supports only DATA_W of 8");
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage
  ssu_pkg::ssu_state_t      state;        // Transfer state
  logic [DATA_W-1:0]        tx_hold;      // Transmit holding buffer
  logic                     tx_full;      // Holding buffer occupied
  logic [DATA_W-1:0]        shreg;        // Shift register
  logic [DATA_W-1:0]        rx_shift;     // Bits gathered so far
  logic [3:0]               edge_cnt;     // Trailing edges done in word
  logic [ssu_pkg::BAUD_W-1:0] baud_cnt;   // Baud down counter
  logic                     sclk_phase;   // Master clock, active sense
  logic                     sclk_q1;      // Slave clock sync stage 1
  logic                     sclk_q2;      // Slave clock sync stage 2
  logic                     sclk_q3;      // Previous synced level
  logic                     tx_bit;       // Bit presented on output
  logic                     rx_pending;   // Word waits unread in rx buffer

  ////////////////////////////////////////////////////////////////////////
  // Derived signals
  logic [3:0] bits;           // Legal word length
  logic       tick;           // Master half period elapsed
  logic       lead_edge;      // Leading edge of shift clock
  logic       trail_edge;     // Trailing edge of shift clock
  logic       sample_edge;    // Edge where input is captured
  logic       shift_edge;     // Edge where output advances
  logic       last_edge;      // Final trailing edge of word
  logic       word_done;      // Whole word shifted
  logic       load_now;       // Holding buffer to shifter
  logic       set_rx_err;
  logic       set_ph_err;
  logic       set_br_err;
  logic       set_tx_err;
  logic [ssu_pkg::FLAG_W-1:0] flag_set;
  logic              rx_in;       // Line the role listens on
  logic [DATA_W-1:0] rx_word;     // Gathered bits incl. this edge

  // Clamp word length to supported range
  // two to eight bits
  always_comb begin
    if (word_bits < 4'(ssu_pkg::MIN_BITS))
      bits = 4'(ssu_pkg::MIN_BITS);
    else if (word_bits > 4'(DATA_W))
      bits = 4'(DATA_W);
    else
      bits = word_bits;
  end

  // Bit index of the n-th bit in chosen order
  function automatic logic [2:0] bit_pos(input logic [3:0] n,
                                         input logic [3:0] len,
                                         input logic       msb);
    logic [3:0] p;
    p = msb ? (len - 4'h1 - n) : n;
    return p[2:0];
  endfunction

  assign tick = master_en && (state == ssu_pkg::SSU_SHIFT)
                && (baud_cnt == '0);

  // Slave edges come from the synced external clock
  // external master clock
  always_comb begin
    if (master_en) begin
      lead_edge  = tick && !sclk_phase;
      trail_edge = tick && sclk_phase;
    end else begin
      lead_edge  = (sclk_q2 ^ clk_idle_high) && !(sclk_q3 ^ clk_idle_high);
      trail_edge = !(sclk_q2 ^ clk_idle_high) && (sclk_q3 ^ clk_idle_high);
    end
  end

  assign sample_edge = shift_trailing ? trail_edge : lead_edge;
  assign shift_edge  = shift_trailing ? lead_edge : trail_edge;
  assign last_edge   = trail_edge && (edge_cnt == bits - 4'h1);
  assign word_done   = (state == ssu_pkg::SSU_SHIFT) && last_edge;
  assign load_now    = (state != ssu_pkg::SSU_SHIFT) && tx_full;
  assign busy        = (state == ssu_pkg::SSU_SHIFT);

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  // write into empty buffer starts word
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ssu_pkg::SSU_IDLE;
    end else begin
      unique case (state)
        ssu_pkg::SSU_IDLE:  if (load_now) state <= ssu_pkg::SSU_SHIFT;
        ssu_pkg::SSU_SHIFT: if (last_edge) state <= ssu_pkg::SSU_DONE;
        ssu_pkg::SSU_DONE:  state <= load_now ? ssu_pkg::SSU_SHIFT
                                             : ssu_pkg::SSU_IDLE;
      endcase
    end
  end

  // Slave clock synchroniser; stage 1 feeds only stage 2
  always_ff @(posedge mclk) begin
    if (reset) begin
      sclk_q1 <= 1'b0;
      sclk_q2 <= 1'b0;
      sclk_q3 <= 1'b0;
    end else begin
      sclk_q1 <= sclk_in;
      sclk_q2 <= sclk_q1;
      sclk_q3 <= sclk_q2;
    end
  end

  // Baud counter reloads every half period
  // 16-bit reload
  always_ff @(posedge mclk) begin
    if (reset || state != ssu_pkg::SSU_SHIFT || baud_cnt == '0)
      baud_cnt <= baud_reload;
    else
      baud_cnt <= baud_cnt - 1'b1;
  end

  // Master clock toggles on each tick, idles inactive
  // idle level applied at pin
  always_ff @(posedge mclk) begin
    if (reset || state != ssu_pkg::SSU_SHIFT)
      sclk_phase <= 1'b0;
    else if (tick)
      sclk_phase <= !sclk_phase;
  end

  // Count trailing edges for exact word length
  // exact clock count
  always_ff @(posedge mclk) begin
    if (reset || state != ssu_pkg::SSU_SHIFT)
      edge_cnt <= 4'h0;
    else if (trail_edge)
      edge_cnt <= edge_cnt + 4'h1;
  end

  // Transmit holding buffer
  // queue next word while shifting
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_hold <= '0;
      tx_full <= 1'b0;
    end else if (tx_write && !tx_full) begin
      tx_hold <= tx_data;
      tx_full <= 1'b1;
    end else if (load_now) begin
      tx_full <= 1'b0;
    end
  end

  // Shift register and output bit
  // order chosen per word
  always_ff @(posedge mclk) begin
    if (reset) begin
      shreg  <= '0;
      tx_bit <= 1'b0;
    end else if (load_now) begin
      shreg  <= tx_hold;
      // Leading-phase mode presents the first bit before any edge
      tx_bit <= tx_hold[bit_pos(4'h0, bits, msb_first)];
    end else if (busy && shift_edge && shift_trailing) begin
      tx_bit <= shreg[bit_pos(edge_cnt, bits, msb_first)];
    end else if (busy && shift_edge && !shift_trailing
                 && (edge_cnt + 4'h1) < bits) begin
      // Trailing edge hands out the next bit; the first is already out
      tx_bit <= shreg[bit_pos(edge_cnt + 4'h1, bits, msb_first)];
    end
  end

  // Receive capture; half duplex when rx disabled
  // receive path optional
  assign rx_in = master_en ? master_rx_slave_tx_line_in
                           : master_tx_slave_rx_line_in;

  // Merge the bit of this edge, so the last one reaches the buffer
  always_comb begin
    rx_word = rx_shift;
    if (busy && sample_edge && rx_enable)
      rx_word[bit_pos(edge_cnt, bits, msb_first)] = rx_in;
  end

  always_ff @(posedge mclk) begin
    if (reset || load_now)
      rx_shift <= '0;
    else
      rx_shift <= rx_word;
  end

  // Receive buffer loads at end of word
  // receive holding buffer
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_data    <= '0;
      rx_pending <= 1'b0;
    end else if (word_done && rx_enable) begin
      // Trailing-phase capture lands its last bit in this very cycle
      rx_data    <= rx_word;
      rx_pending <= 1'b1;
    end else if (rx_read) begin
      rx_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error detection
  // receive, phase, baud, transmit faults
  assign set_rx_err = word_done && rx_enable && rx_pending && !rx_read;
  assign set_ph_err = !master_en && busy && shift_edge
                      && (edge_cnt >= bits);
  assign set_br_err = master_en && load_now && (baud_reload == '0);
  assign set_tx_err = !master_en && !busy && !tx_full && tx_enable
                      && (sclk_q2 != sclk_q3);

  always_comb begin
    flag_set = '0;
    flag_set[ssu_pkg::F_TX_EMPTY] = load_now; // buffer emptied
    flag_set[ssu_pkg::F_RX_FULL]  = word_done && rx_enable;
    flag_set[ssu_pkg::F_RX_ERR]   = set_rx_err;
    flag_set[ssu_pkg::F_PH_ERR]   = set_ph_err;
    flag_set[ssu_pkg::F_BR_ERR]   = set_br_err;
    flag_set[ssu_pkg::F_TX_ERR]   = set_tx_err;
  end

  // Sticky flags; a set in the clear cycle wins
  // sticky until cleared
  always_ff @(posedge mclk) begin
    if (reset)
      status <= ssu_pkg::FLAG_RESET;
    else
      status <= (status & ~status_clear) | flag_set;
  end

  assign irq_tx  = status[ssu_pkg::F_TX_EMPTY] &
                   irq_enable[ssu_pkg::F_TX_EMPTY];
  assign irq_rx  = status[ssu_pkg::F_RX_FULL] &
                   irq_enable[ssu_pkg::F_RX_FULL];
  assign irq_err = |(status[ssu_pkg::F_TX_ERR:ssu_pkg::F_RX_ERR] &
                     irq_enable[ssu_pkg::F_TX_ERR:ssu_pkg::F_RX_ERR]);

  ////////////////////////////////////////////////////////////////////////
  // Pins
  // clock pin driven only as master
  assign master_shift_clock_out = sclk_phase ^ clk_idle_high;
  assign sclk_oe                = master_en;
  assign master_tx_slave_rx_line_out = tx_bit;
  assign master_tx_slave_rx_line_oe  = master_en && tx_enable;
  assign master_rx_slave_tx_line_out = tx_bit;
  assign master_rx_slave_tx_line_oe  = !master_en && tx_enable;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_clk_pin_role: assert property (@(posedge mclk) disable iff (reset)
    !master_en |-> !sclk_oe) else $error("clock pin driven as slave");
  a_clk_idle_lvl: assert property (@(posedge mclk) disable iff (reset)
    !busy |-> master_shift_clock_out == clk_idle_high)
    else $error("clock not at idle level");
  a_word_edges: assert property (@(posedge mclk) disable iff (reset)
    busy |-> edge_cnt < bits) else $error("too many clock edges");
  a_rx_flag_set: assert property (@(posedge mclk) disable iff (reset)
    word_done && rx_enable |=> status[ssu_pkg::F_RX_FULL])
    else $error("rx full flag missed");
  a_tx_flag_set: assert property (@(posedge mclk) disable iff (reset)
    load_now |=> status[ssu_pkg::F_TX_EMPTY] && busy)
    else $error("tx empty flag or start missed");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
    status[ssu_pkg::F_RX_ERR] && !status_clear[ssu_pkg::F_RX_ERR]
    |=> status[ssu_pkg::F_RX_ERR]) else $error("flag dropped");
  a_err_irq: assert property (@(posedge mclk) disable iff (reset)
    set_br_err && irq_enable[ssu_pkg::F_BR_ERR]
    && $stable(irq_enable) |=> irq_err)
    else $error("error irq missing");
  a_slave_tx_pin: assert property (@(posedge mclk) disable iff (reset)
    master_en |-> !master_rx_slave_tx_line_oe)
    else $error("master drove slave line");
  c_master_word: cover property (@(posedge mclk) master_en && word_done);
  c_slave_word: cover property (@(posedge mclk) !master_en && word_done);
  c_back_to_back: cover property (@(posedge mclk)
    state == ssu_pkg::SSU_DONE && load_now);
endmodule // ssu_port

// >>> verification/ssu_spi_partner.sv
// Behavioural far-side SPI slave used while the unit is master
`timescale 1ns/1ps
module ssu_spi_partner (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       msb,
  input  wire logic [3:0] bits,
  input  wire logic       load,
  input  wire logic [7:0] word,
  output logic            miso,
  output logic [7:0]      got
);
  int n; // Bits captured so far
  // Bit index of the k-th bit on the wire
  function automatic int pos(input int k);
    return msb ? int'(bits) - 1 - k : k;
  endfunction
  initial miso = 1'b0;
  // Leading-edge capture needs the first bit before any clock edge
  always @(posedge load) begin
    n = 0;
    got = 8'h00;
    miso = cpha ? ~miso : word[pos(0)];
  end
  ////////////////////////////////////////////////////////////////////////
  // edge roles follow idle level and phase
  always @(sclk) begin
    if ((sclk !== cpol) != cpha) begin
      if (n < bits) got[pos(n)] = mosi;
      n++;
    end else if (n < bits) begin
      miso = word[pos(n)];
    end else begin
      miso = ~miso; // Released line, no pull: never the last value
    end
  end
endmodule // ssu_spi_partner

// >>> verification/tb.sv
// Self-checking bench for the synchronous serial unit
`timescale 1ns/1ps
module tb;
  logic       mclk, reset, master_en, msb_first, clk_idle_high;
  logic       shift_trailing, tx_enable, rx_enable, tx_write, rx_read;
  logic       busy, irq_tx, irq_rx, irq_err, sclk_out, sclk_oe;
  logic       mosi_out, mosi_oe, miso_out, miso_oe, s_clk, s_mosi;
  logic       p_miso, p_load, sclk_w, mosi_w, miso_w;
  logic [3:0] word_bits;
  logic [15:0] baud_reload;
  logic [7:0] tx_data, rx_data, p_word, p_got, s_got;
  logic [5:0] status, status_clear, irq_enable;
  int         n_fail, n_compared, n_edges;
  // Wire levels from every party's enable; undriven lines keep moving
  assign sclk_w = sclk_oe ? sclk_out : s_clk;
  assign mosi_w = mosi_oe ? mosi_out : (master_en ? mclk : s_mosi);
  assign miso_w = miso_oe ? miso_out : (master_en ? p_miso : mclk);
  ssu_port u_dut (
    .mclk(mclk), .reset(reset), .master_en(master_en),
    .word_bits(word_bits), .msb_first(msb_first),
    .clk_idle_high(clk_idle_high), .shift_trailing(shift_trailing),
    .tx_enable(tx_enable), .rx_enable(rx_enable),
    .baud_reload(baud_reload), .tx_data(tx_data), .tx_write(tx_write),
    .rx_data(rx_data), .rx_read(rx_read), .busy(busy), .status(status),
    .status_clear(status_clear), .irq_enable(irq_enable),
    .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err),
    .sclk_in(sclk_w), .master_shift_clock_out(sclk_out),
    .sclk_oe(sclk_oe), .master_tx_slave_rx_line_in(mosi_w),
    .master_tx_slave_rx_line_out(mosi_out),
    .master_tx_slave_rx_line_oe(mosi_oe),
    .master_rx_slave_tx_line_in(miso_w),
    .master_rx_slave_tx_line_out(miso_out),
    .master_rx_slave_tx_line_oe(miso_oe));
  ssu_spi_partner u_far (
    .sclk(sclk_w), .mosi(mosi_w), .cpol(clk_idle_high),
    .cpha(shift_trailing), .msb(msb_first), .bits(word_bits),
    .load(p_load), .word(p_word), .miso(p_miso), .got(p_got));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Every shift clock transition, to count cycles per word
  always @(sclk_out) n_edges++;
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for busy low, or for tx empty when on_busy is 0
  task automatic wait_low(input bit on_busy);
    int k;
    k = 0;
    repeat (2) @(negedge mclk);
    while ((on_busy ? busy : !status[0]) !== 1'b0 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic send(input logic [7:0] d);
    @(negedge mclk);
    tx_data = d;
    tx_write = 1'b1;
    @(negedge mclk);
    tx_write = 1'b0;
  endtask
  function automatic logic [7:0] mk(input logic [3:0] b);
    return 8'((9'h001 << b) - 9'h001);
  endfunction
  // One master word in the given format against the partner
  task automatic xfer(input logic pol, input logic ph, input logic msb,
                      input logic [3:0] b, input logic [7:0] d,
                      input logic [7:0] pw);
    clk_idle_high = pol;
    shift_trailing = ph;
    msb_first = msb;
    word_bits = b;
    repeat (3) @(negedge mclk);
    p_word = pw;
    p_load = 1'b1;
    @(negedge mclk);
    p_load = 1'b0;
    n_edges = 0;
    send(d);
    wait_low(1'b1);
    @(negedge mclk);
    check(8'(n_edges), 8'(2 * b));
    check(p_got, d & mk(b));
    check(rx_data & mk(b), pw & mk(b));
    check(8'(status[1]), 8'h01);
    check(8'(sclk_out), 8'(pol));
  endtask
  // Unit as slave: bench plays the master, mode 0, MSB first
  task automatic s_byte(input logic [7:0] d);
    for (int k = 7; k >= 0; k--) begin
      s_mosi = d[k];
      repeat (4) @(negedge mclk);
      s_got[k] = miso_w;
      s_clk = 1'b1;
      repeat (4) @(negedge mclk);
      s_clk = 1'b0;
    end
    repeat (6) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {n_fail, n_compared, n_edges} = '0;
    {reset, master_en, tx_enable, rx_enable} = 4'hF;
    {msb_first, clk_idle_high, shift_trailing, tx_write} = 4'h0;
    {rx_read, s_clk, s_mosi, p_load} = 4'h0;
    word_bits = 4'h8;
    baud_reload = 16'h0001;
    {tx_data, p_word} = 16'h0000;
    status_clear = 6'h00;
    irq_enable = 6'h3F;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    check(8'(status), 8'h01);
    check(8'(sclk_out), 8'h00);
    check(8'(sclk_oe), 8'h01);
    for (int i = 0; i < 8; i++) begin
      xfer(i[0], i[1], i[2], 4'(2 + i % 7), 8'h5A ^ 8'(i * 37),
           8'hC3 ^ 8'(i * 11));
      rx_read = 1'b1;
      @(negedge mclk);
      rx_read = 1'b0;
    end
    // Two queued words, nothing read: overrun; full-width words from here
    word_bits = 4'h8;
    repeat (2) @(negedge mclk);
    n_edges = 0;
    send(8'h11);
    wait_low(1'b0);
    send(8'h22);
    wait_low(1'b1);
    wait_low(1'b1);
    repeat (5) @(negedge mclk);
    check(8'(n_edges), 8'h20);
    check(8'(status[2]), 8'h01);
    check(8'(irq_err), 8'h01);
    irq_enable = 6'h00;
    @(negedge mclk);
    check({6'h00, irq_tx, irq_rx}, 8'h00);
    irq_enable = 6'h3F;
    @(negedge mclk);
    check({6'h00, irq_tx, irq_rx}, 8'h03);
    status_clear = 6'h06;
    @(negedge mclk);
    status_clear = 6'h00;
    @(negedge mclk);
    check({5'h00, status[2:1], irq_err}, 8'h00);
    // Half duplex: receive only
    tx_enable = 1'b0;
    p_word = 8'h96;
    p_load = 1'b1;
    @(negedge mclk);
    p_load = 1'b0;
    send(8'hFF);
    repeat (4) @(negedge mclk);
    check(8'(mosi_oe), 8'h00);
    wait_low(1'b1);
    @(negedge mclk);
    check(rx_data, 8'h96);
    tx_enable = 1'b1;
    // Slave role
    master_en = 1'b0;
    {msb_first, clk_idle_high, shift_trailing} = 3'b100;
    // Pin hand-over looks like a slave edge; wipe that underrun flag
    status_clear = 6'h20;
    repeat (4) @(negedge mclk);
    status_clear = 6'h00;
    check(8'(sclk_oe), 8'h00);
    check(8'(status[5]), 8'h00);
    send(8'hA5);
    repeat (4) @(negedge mclk);
    s_byte(8'h3C);
    check(rx_data, 8'h3C);
    check(s_got, 8'hA5);
    check(8'(mosi_oe), 8'h00);
    // Clocked with nothing queued
    s_byte(8'h0F);
    check(8'(status[5]), 8'h01);
    // Zero reload flagged as a baud fault
    master_en = 1'b1;
    baud_reload = 16'h0000;
    send(8'h01);
    repeat (4) @(negedge mclk);
    check(8'(status[4]), 8'h01);
    conclude();
  end
endmodule // tb
